// File: design/ebpc_pkg.sv
package ebpc_pkg;
  // Printed register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
  localparam logic [7:0] IDX_PORT_B_DATA = 8'h01;
  localparam logic [7:0] IDX_PORT_A_DIR = 8'h02;
  localparam logic [7:0] IDX_PORT_B_DIR = 8'h03;
  localparam logic [7:0] IDX_PORT_E_DATA = 8'h08;
  localparam logic [7:0] IDX_PORT_E_DIR = 8'h09;
  localparam logic [7:0] IDX_BUS_MISC = 8'h13;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h0b;
  localparam logic [7:0] IDX_PULL_CTRL = 8'h0c;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  // Misc control field positions
  localparam int MISC_LARGE_FLASH = 0;
  localparam int MISC_SMALL_FLASH = 1;
  localparam int MISC_EXT_STR_LO = 2;
  localparam int MISC_FR_STR_LO = 4;
  localparam int MISC_NARROW = 6;
  // Reset values of misc control by mode group
  localparam logic [7:0] MISC_RST_EXP = 8'h0c;
  localparam logic [7:0] MISC_RST_SC = 8'h0f;
  // Port E direction: only bits 7..2 are writable
  localparam logic [7:0] PE_DIR_MASK = 8'hfc;
  localparam logic [7:0] PE_DIR_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  // Mode control bit positions
  localparam int MODE_EMULATE_E = 0;
  // Register-following region: index 0x200..0x3ff bytes of the 2K block
  localparam logic [15:0] FOLLOW_BASE = 16'h0200;
  localparam logic [15:0] FOLLOW_LAST = 16'h03ff;
  localparam logic [15:0] EXP_REG_LAST = 16'h000f;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_SINGLE_CHIP = 3'b000,
    MODE_EXP_NARROW = 3'b001,
    MODE_PERIPHERAL = 3'b010,
    MODE_EXP_WIDE = 3'b011
  } ebpc_mode_type;
  // External cycle sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_STRETCH = 2'b10,
    ST_DATA = 2'b11
  } ebpc_state_type;
endpackage

// File: design/ebpc_top.sv
`timescale 1ns/1ns
// What this block does
// R1 - Follow region stretch of 0 to 3 E clocks
// R2 - Follow stretch applies in narrow or wide
// R3 - External stretch 0 to 3, ignored otherwise
// R4 - Two flash enable bits map the arrays
// R5 - Strobe and A0 high only for RAM misaligned
// R6 - Byte access: strobe and A0 by parity
// R7 - Word access: even low, swapped both high
// R8 - Peripheral mode drops first 16 expansion registers
// R9 - Expanded modes drop ports A, B registers
// R10 - Expanded with emulate bit drops port E
// R11 - Port E data absent peripheral or emulated
// R12 - Port A carries high address and data
// R13 - Port B carries low address, data if wide
// R14 - Direction bit zero input, one output
// R15 - Port E alternates chosen by assignment register
// R16 - One bit enables port E control pull-ups
// R17 - Port E direction bits 1:0 read zero
// R18 - Internal 16-bit, external 8 or 16 bits
// R19 - Designer may put byte devices in follow region
// R20 - Narrow follow region passes data via port A
// R21 - Stretch extends E high before completing
module ebpc_top #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operating mode strap, sampled every cycle
  input wire logic [2:0] mode_sel,
  // CPU bus request towards the external bus
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic cpu_word,
  input wire logic cpu_ram,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic [15:0] reg_base,
  output logic [15:0] cpu_rdata,
  output logic cpu_done,
  // Memory map decisions
  output logic small_flash_array,
  output logic large_flash_array,
  // Port A and B pins
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_n,
  // Port E pins
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_out,
  output logic [7:0] port_e_oe_n,
  output logic [7:0] port_e_pull_en,
  input wire logic [7:0] port_e_assignment
);
  initial begin
    if (ADDR_W < 10) begin
      $error("ADDR_W too small");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rst_n = rst_sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding
  ebpc_pkg::ebpc_mode_type mode;
  assign mode = ebpc_pkg::ebpc_mode_type'(mode_sel);
  wire logic is_exp = (mode == ebpc_pkg::MODE_EXP_NARROW) ||
                      (mode == ebpc_pkg::MODE_EXP_WIDE);
  wire logic is_periph = (mode == ebpc_pkg::MODE_PERIPHERAL);
  wire logic is_narrow = (mode == ebpc_pkg::MODE_EXP_NARROW);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] port_a_data_ff, port_b_data_ff;
  logic [7:0] port_a_dir_ff, port_b_dir_ff;
  logic [7:0] port_e_data_ff, port_e_dir_ff;
  logic [7:0] misc_ff;
  logic [7:0] mode_ctrl_ff;
  logic pull_e_ff;
  logic misc_init_ff;

  wire logic emulate_port_e_bit = mode_ctrl_ff[ebpc_pkg::MODE_EMULATE_E];
  wire logic [7:0] idx = ((paddr >> 10) == '0) ? paddr[9:2] : '1; // No alias
  wire logic wr_en = psel && penable && pwrite;

  // Map presence of each register
  wire logic ab_mapped = !is_exp && !is_periph; // R9 R8
  wire logic e_mapped = !is_periph && !(is_exp && emulate_port_e_bit); // R10 R11
  wire logic hit_a = ab_mapped && (idx == ebpc_pkg::IDX_PORT_A_DATA);
  wire logic hit_b = ab_mapped && (idx == ebpc_pkg::IDX_PORT_B_DATA);
  wire logic hit_ad = ab_mapped && (idx == ebpc_pkg::IDX_PORT_A_DIR);
  wire logic hit_bd = ab_mapped && (idx == ebpc_pkg::IDX_PORT_B_DIR);
  wire logic hit_e = e_mapped && (idx == ebpc_pkg::IDX_PORT_E_DATA);
  wire logic hit_ed = e_mapped && (idx == ebpc_pkg::IDX_PORT_E_DIR);
  wire logic hit_misc = idx == ebpc_pkg::IDX_BUS_MISC;
  wire logic hit_mode = !is_periph && (idx == ebpc_pkg::IDX_MODE_CTRL); // R8
  wire logic hit_pull = !is_periph && (idx == ebpc_pkg::IDX_PULL_CTRL); // R8
  wire logic hit_stat = idx == ebpc_pkg::IDX_STATUS;
  wire logic hit_any = hit_a || hit_b || hit_ad || hit_bd || hit_e ||
                       hit_ed || hit_misc || hit_mode || hit_pull || hit_stat;

  // Port A/B data and direction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_data_ff <= ebpc_pkg::PORT_RST;
      port_b_data_ff <= ebpc_pkg::PORT_RST;
      port_a_dir_ff <= ebpc_pkg::PORT_RST;
      port_b_dir_ff <= ebpc_pkg::PORT_RST;
    end else if (wr_en) begin
      if (hit_a) begin
        port_a_data_ff <= pwdata[7:0];
      end else if (hit_b) begin
        port_b_data_ff <= pwdata[7:0];
      end else if (hit_ad) begin
        port_a_dir_ff <= pwdata[7:0];
      end else if (hit_bd) begin
        port_b_dir_ff <= pwdata[7:0];
      end
    end
  end

  // Port E data and direction
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_e_data_ff <= ebpc_pkg::PORT_RST;
      port_e_dir_ff <= ebpc_pkg::PE_DIR_RST;
    end else if (wr_en) begin
      if (hit_e) begin
        port_e_data_ff <= pwdata[7:0];
      end else if (hit_ed) begin
        port_e_dir_ff <= pwdata[7:0] & ebpc_pkg::PE_DIR_MASK; // R17
      end
    end
  end

  // Misc control: reset value depends on mode, loaded after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_ff <= ebpc_pkg::MISC_RST_EXP;
      misc_init_ff <= 1'b0;
    end else if (!misc_init_ff) begin
      misc_init_ff <= 1'b1;
      misc_ff <= is_exp ? ebpc_pkg::MISC_RST_EXP : ebpc_pkg::MISC_RST_SC;
    end else if (wr_en && hit_misc) begin
      misc_ff <= pwdata[7:0];
    end
  end

  // Mode control and pull-up enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl_ff <= ebpc_pkg::PORT_RST;
      pull_e_ff <= 1'b1;
    end else if (wr_en && hit_mode) begin
      mode_ctrl_ff <= pwdata[7:0];
    end else if (wr_en && hit_pull) begin
      pull_e_ff <= pwdata[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read and answer: zero wait states
  ebpc_pkg::ebpc_state_type state_ff;
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_a) begin
      rd_mux = port_a_data_ff;
    end else if (hit_b) begin
      rd_mux = port_b_data_ff;
    end else if (hit_ad) begin
      rd_mux = port_a_dir_ff;
    end else if (hit_bd) begin
      rd_mux = port_b_dir_ff;
    end else if (hit_e) begin
      rd_mux = (port_e_dir_ff & port_e_data_ff) |
               (~port_e_dir_ff & port_e_in);
    end else if (hit_ed) begin
      rd_mux = port_e_dir_ff & ebpc_pkg::PE_DIR_MASK; // R17
    end else if (hit_misc) begin
      rd_mux = misc_ff;
    end else if (hit_mode) begin
      rd_mux = mode_ctrl_ff;
    end else if (hit_pull) begin
      rd_mux = {3'h0, pull_e_ff, 4'h0};
    end else if (hit_stat) begin
      rd_mux = {3'h0, mode_sel, state_ff};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= {24'h00_0000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash array enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      small_flash_array <= 1'b0;
      large_flash_array <= 1'b0;
    end else begin
      small_flash_array <= misc_ff[ebpc_pkg::MISC_SMALL_FLASH]; // R4
      large_flash_array <= misc_ff[ebpc_pkg::MISC_LARGE_FLASH]; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External cycle sequencer
  function automatic logic in_follow(input logic [15:0] a,
                                     input logic [15:0] base);
    logic [15:0] off;
    off = a - base;
    in_follow = (off >= ebpc_pkg::FOLLOW_BASE) &&
                (off <= ebpc_pkg::FOLLOW_LAST);
  endfunction

  logic [1:0] stretch_cnt_ff;
  logic [15:0] addr_ff, wdata_ff;
  logic wr_ff, word_ff, ram_ff, narrow_ff;
  logic e_clk_ff, strobe_n_ff, rw_ff;
  wire logic follow_hit = in_follow(cpu_addr, reg_base);
  wire logic [1:0] fr_str = misc_ff[ebpc_pkg::MISC_FR_STR_LO +: 2];
  wire logic [1:0] ex_str = misc_ff[ebpc_pkg::MISC_EXT_STR_LO +: 2];
  // Narrow-bus follow region only in wide expanded mode
  wire logic follow_narrow = (mode == ebpc_pkg::MODE_EXP_WIDE) &&
                             misc_ff[ebpc_pkg::MISC_NARROW] && follow_hit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ebpc_pkg::ST_IDLE;
      stretch_cnt_ff <= 2'h0;
      addr_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
      wr_ff <= 1'b0;
      word_ff <= 1'b0;
      ram_ff <= 1'b0;
      narrow_ff <= 1'b0;
      cpu_done <= 1'b0;
    end else begin
      cpu_done <= 1'b0;
      case (state_ff)
        ebpc_pkg::ST_IDLE: begin
          if (cpu_req && is_exp) begin
            state_ff <= ebpc_pkg::ST_ADDR;
            addr_ff <= cpu_addr;
            wdata_ff <= cpu_wdata;
            wr_ff <= cpu_wr;
            word_ff <= cpu_word;
            ram_ff <= cpu_ram;
            narrow_ff <= is_narrow || follow_narrow; // R18 R20
            stretch_cnt_ff <= follow_hit ? fr_str : ex_str; // R1 R2 R3
          end
        end
        ebpc_pkg::ST_ADDR: begin
          state_ff <= (stretch_cnt_ff != 2'h0) ? ebpc_pkg::ST_STRETCH
                                               : ebpc_pkg::ST_DATA;
        end
        ebpc_pkg::ST_STRETCH: begin
          // Hold E high one cycle per stretched E clock
          stretch_cnt_ff <= stretch_cnt_ff - 2'h1; // R21
          if (stretch_cnt_ff == 2'h1) begin
            state_ff <= ebpc_pkg::ST_DATA;
          end
        end
        ebpc_pkg::ST_DATA: begin
          state_ff <= ebpc_pkg::ST_IDLE;
          cpu_done <= 1'b1;
        end
        default: state_ff <= ebpc_pkg::ST_IDLE;
      endcase
    end
  end

  // Read data capture; narrow bus returns the byte on port A
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 16'h0000;
    end else if (state_ff == ebpc_pkg::ST_DATA && !wr_ff) begin
      if (narrow_ff) begin
        cpu_rdata <= {8'h00, port_a_in}; // R20
      end else begin
        cpu_rdata <= {port_a_in, port_b_in};
      end
    end
  end

  // Bus control: E clock, strobe and read/write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      e_clk_ff <= 1'b0;
      strobe_n_ff <= 1'b1;
      rw_ff <= 1'b1;
    end else begin
      e_clk_ff <= (state_ff == ebpc_pkg::ST_ADDR) ||
                  (state_ff == ebpc_pkg::ST_STRETCH); // R21
      rw_ff <= (state_ff == ebpc_pkg::ST_IDLE) ? 1'b1 : !wr_ff; // R6 R7
      if (state_ff == ebpc_pkg::ST_IDLE) begin
        strobe_n_ff <= 1'b1;
      end else if (word_ff) begin
        // Word: low when aligned, high when swapped or RAM misaligned
        strobe_n_ff <= addr_ff[0] && ram_ff; // R5 R7
      end else begin
        strobe_n_ff <= !addr_ff[0]; // R6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers for ports A and B
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_out <= 8'h00;
      port_a_oe_n <= 8'hff;
      port_b_out <= 8'h00;
      port_b_oe_n <= 8'hff;
    end else if (is_exp || is_periph) begin
      // Address shows with the address state, so reads meet a released bus
      if (state_ff == ebpc_pkg::ST_IDLE) begin
        port_a_out <= cpu_addr[15:8]; // R12
        port_b_out <= cpu_addr[7:0]; // R13
      end else if (narrow_ff) begin
        port_a_out <= addr_ff[0] ? wdata_ff[7:0] : wdata_ff[15:8]; // R12
        port_b_out <= addr_ff[7:0]; // R13
      end else if (ram_ff && addr_ff[0]) begin
        port_a_out <= wdata_ff[7:0]; // R5
        port_b_out <= wdata_ff[15:8];
      end else begin
        port_a_out <= wdata_ff[15:8];
        port_b_out <= wdata_ff[7:0];
      end
      port_a_oe_n <= (state_ff != ebpc_pkg::ST_IDLE && !wr_ff) ? 8'hff
                                                               : 8'h00;
      port_b_oe_n <= (state_ff != ebpc_pkg::ST_IDLE && !wr_ff &&
                      !narrow_ff) ? 8'hff : 8'h00;
    end else begin
      port_a_out <= port_a_data_ff;
      port_a_oe_n <= ~port_a_dir_ff; // R14
      port_b_out <= port_b_data_ff;
      port_b_oe_n <= ~port_b_dir_ff; // R14
    end
  end

  // Port E: alternates when assigned in expanded modes, else general purpose
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_e_out <= 8'h00;
      port_e_oe_n <= 8'hff;
      port_e_pull_en <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (port_e_assignment[i] && is_exp) begin
          port_e_oe_n[i] <= (i < 2); // R15
          case (i)
            7: port_e_out[i] <= !e_clk_ff;
            4: port_e_out[i] <= e_clk_ff;
            3: port_e_out[i] <= strobe_n_ff;
            2: port_e_out[i] <= rw_ff;
            default: port_e_out[i] <= port_e_data_ff[i];
          endcase
        end else begin
          port_e_out[i] <= port_e_data_ff[i];
          port_e_oe_n[i] <= !port_e_dir_ff[i]; // R14 R17
        end
      end
      // Pull-ups on control pins whose direction bit is clear
      port_e_pull_en <= {8{pull_e_ff}} & 8'h8f &
                        ~(port_e_dir_ff & ebpc_pkg::PE_DIR_MASK); // R16
    end
  end
endmodule

// File: bench/ebpc_properties.sv
`timescale 1ns/1ns
module ebpc_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] mode_sel,
  input wire logic cpu_done,
  input wire logic small_flash_array,
  input wire logic large_flash_array,
  input wire logic [7:0] port_a_oe_n
);
  logic [ADDR_W-3:0] idx;
  logic wr_ok;
  logic [7:0] dir_a_ff;
  logic [1:0] flash_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the written direction and flash bits
  assign idx = paddr[ADDR_W-1:2];
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dir_a_ff <= 8'h00;
      flash_ff <= 2'h0;
    end else if (wr_ok && idx == 2) begin
      dir_a_ff <= pwdata[7:0];
    end else if (wr_ok && idx == 8'h13) begin
      flash_ff <= pwdata[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (s_done ##0 (idx == '1) |-> pslverr)
    else $error("unmapped access not refused");
  a_exp_ports_gone: assert property (s_done ##0
    (mode_sel != ebpc_pkg::MODE_SINGLE_CHIP && idx < 4) |-> pslverr)
    else $error("port register visible in expanded mode");
  a_dir_low_zero: assert property (s_done ##0
    (!pwrite && !pslverr && idx == 9) |-> prdata[1:0] == 2'b00)
    else $error("port e direction low bits not zero");
  a_done_pulse: assert property (cpu_done |=> !cpu_done)
    else $error("cpu_done longer than one cycle");
  a_done_expanded: assert property (cpu_done |->
    (mode_sel == ebpc_pkg::MODE_EXP_NARROW ||
     mode_sel == ebpc_pkg::MODE_EXP_WIDE))
    else $error("external cycle outside expanded mode");
  a_dir_oe_follow: assert property (wr_ok && idx == 2 &&
    mode_sel == ebpc_pkg::MODE_SINGLE_CHIP |=> ##[0:1]
    port_a_oe_n == ~dir_a_ff) else $error("port a enable wrong");
  a_flash_map: assert property (wr_ok && idx == 8'h13 |=> ##[0:1]
    large_flash_array == flash_ff[0] && small_flash_array == flash_ff[1])
    else $error("flash enable wrong");
endmodule
bind ebpc_top ebpc_checker #(.ADDR_W(ADDR_W)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mode_sel(mode_sel),
  .cpu_done(cpu_done), .small_flash_array(small_flash_array),
  .large_flash_array(large_flash_array), .port_a_oe_n(port_a_oe_n));

// File: bench/ebpc_ext_bus_model.sv
`timescale 1ns/1ns
module ebpc_ext_bus_model #(
  parameter logic [7:0] DATA_HI = 8'h5a,
  parameter logic [7:0] DATA_LO = 8'hc3
) (
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe_n,
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in
);
  // Wire level: device bit where it drives, memory data where released
  assign port_a_in = (port_a_out & ~port_a_oe_n) | (DATA_HI & port_a_oe_n);
  assign port_b_in = (port_b_out & ~port_b_oe_n) | (DATA_LO & port_b_oe_n);
endmodule

// File: bench/ebpc_top_tb.sv
`timescale 1ns/1ns
module ebpc_top_tb;
  typedef struct {
    logic wr;
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
    logic err;
  } ebpc_row_type;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] mode_sel;
  logic cpu_req, cpu_wr, cpu_word, cpu_ram, cpu_done;
  logic [15:0] cpu_addr, cpu_wdata, reg_base, cpu_rdata;
  logic small_flash_array, large_flash_array;
  logic [7:0] port_a_in, port_a_out, port_a_oe_n, port_b_in, port_b_out;
  logic [7:0] port_b_oe_n, port_e_in, port_e_out, port_e_oe_n;
  logic [7:0] port_e_pull_en, port_e_assignment, rd, mv;
  logic er;
  int n_mismatch, checked, lat, base, i;
  ebpc_row_type rows [7];
  ////////////////////////////////////////////////////////////////////////////
  ebpc_top dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_sel(mode_sel), .cpu_req(cpu_req), .cpu_wr(cpu_wr),
    .cpu_word(cpu_word), .cpu_ram(cpu_ram), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .reg_base(reg_base), .cpu_rdata(cpu_rdata),
    .cpu_done(cpu_done), .small_flash_array(small_flash_array),
    .large_flash_array(large_flash_array), .port_a_in(port_a_in),
    .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
    .port_b_in(port_b_in), .port_b_out(port_b_out),
    .port_b_oe_n(port_b_oe_n), .port_e_in(port_e_in),
    .port_e_out(port_e_out), .port_e_oe_n(port_e_oe_n),
    .port_e_pull_en(port_e_pull_en), .port_e_assignment(port_e_assignment));
  ebpc_ext_bus_model u_ext (.port_a_out(port_a_out),
    .port_a_oe_n(port_a_oe_n), .port_b_out(port_b_out),
    .port_b_oe_n(port_b_oe_n), .port_a_in(port_a_in), .port_b_in(port_b_in));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("ERROR %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    cmp_val({7'h00, pready}, 8'h01);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [2:0] m);
    @(posedge ref_clk);
    nrst <= 1'b0;
    mode_sel <= m;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  // Counts settled cycles from launch to done, 30 meaning never
  task automatic cpu_cycle(input logic [15:0] a);
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    lat = 0;
    do begin
      @(negedge ref_clk);
      lat++;
    end while (cpu_done !== 1'b1 && lat < 30);
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, cpu_req, cpu_wr, cpu_ram} = 7'h00;
    cpu_word = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    mode_sel = ebpc_pkg::MODE_SINGLE_CHIP;
    {cpu_addr, cpu_wdata, reg_base} = {16'h0000, 16'h1234, 16'h0000};
    {port_e_in, port_e_assignment} = {8'h00, 8'h00};
    n_mismatch = 0;
    checked = 0;
    base = 3; // Take edge, address and data cycles
    rows = '{'{1'b0, 10'h013, 8'h00, 8'h0f, 1'b0},
             '{1'b1, 10'h002, 8'ha5, 8'h00, 1'b0},
             '{1'b0, 10'h002, 8'h00, 8'ha5, 1'b0},
             '{1'b0, 10'h009, 8'h00, 8'h00, 1'b0},
             '{1'b1, 10'h009, 8'hff, 8'h00, 1'b0},
             '{1'b0, 10'h009, 8'h00, 8'hfc, 1'b0},
             '{1'b0, 10'h3ff, 8'h00, 8'h00, 1'b1}};
    do_reset(ebpc_pkg::MODE_SINGLE_CHIP);
    @(negedge ref_clk);
    cmp_val({6'h00, small_flash_array, large_flash_array}, 8'h03);
    for (i = 0; i < 7; i++) begin
      apb(rows[i].wr, rows[i].idx, rows[i].wd);
      cmp_val({7'h00, er}, {7'h00, rows[i].err});
      if (!rows[i].wr) cmp_val(rd, rows[i].exp);
    end
    @(negedge ref_clk);
    cmp_val(port_a_oe_n, 8'h5a);
    cmp_val(port_e_oe_n, 8'h03);
    cmp_val(port_e_pull_en, 8'h03);
    apb(1'b1, 10'h013, 8'h02);
    repeat (2) @(negedge ref_clk);
    cmp_val({6'h00, small_flash_array, large_flash_array}, 8'h02);
    cpu_cycle(16'h4000);
    cmp_cnt(lat, 30);
    // Each stretch value, external then follow region, then narrow follow
    for (i = 0; i < 9; i++) begin
      do_reset(ebpc_pkg::MODE_EXP_WIDE);
      if (i == 0) begin
        apb(1'b0, 10'h013, 8'h00);
        cmp_val(rd, 8'h0c);
      end
      mv = (i < 4) ? 8'(i << 2) : (i < 8) ? 8'((i - 4) << 4) : 8'h60;
      apb(1'b1, 10'h013, mv);
      cpu_cycle((i < 4) ? 16'h4000 : 16'h0200);
      cmp_cnt(lat, base + ((i < 4) ? i : (i < 8) ? i - 4 : 2));
      cmp_val(cpu_rdata[15:8], (i == 8) ? 8'h00 : 8'h5a);
      cmp_val(cpu_rdata[7:0], (i == 8) ? 8'h5a : 8'hc3);
    end
    // Bus control pins on port E: byte read odd, then word write even
    @(posedge ref_clk);
    port_e_assignment <= 8'h0c;
    cpu_word <= 1'b0;
    cpu_cycle(16'h4001);
    cmp_val({6'h00, port_e_out[3:2]}, 8'h01);
    @(posedge ref_clk);
    {cpu_word, cpu_wr} <= 2'b11;
    cpu_cycle(16'h4000);
    cmp_val({6'h00, port_e_out[3:2]}, 8'h00);
    apb(1'b0, 10'h008, 8'h00);
    cmp_val({7'h00, er}, 8'h00);
    apb(1'b1, 10'h00b, 8'h01);
    apb(1'b0, 10'h008, 8'h00);
    cmp_val({7'h00, er}, 8'h01);
    apb(1'b0, 10'h000, 8'h00);
    cmp_val({7'h00, er}, 8'h01);
    do_reset(ebpc_pkg::MODE_PERIPHERAL);
    apb(1'b0, 10'h008, 8'h00);
    cmp_val({7'h00, er}, 8'h01);
    cpu_cycle(16'h4000);
    cmp_cnt(lat, 30);
    close_out();
  end
endmodule
